// File: bench/link_deser_alias_scratch_regs_tb.sv
/*
  Self-checking bench for the register slice.
  Assumes default OSC_DIV of 5 core cycles per oscillator tick.
*/
`timescale 1ns/1ps
module link_deser_alias_scratch_regs_tb;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic TXN_VALID = 1'b0;
  logic [6:0] TXN_ADDR = 7'h00;
  logic AUDIO_PLL_LOCKED = 1'b0;
  logic pix_run = 1'b0;
  logic [7:0] pix_half = 8'h14;
  wire [7:0] REG_RDATA;
  wire REG_RVALID;
  wire FWD_VALID;
  wire [6:0] FWD_ADDR;
  wire FWD_REMAPPED;
  wire PIXEL_CLK;
  int bad_count = 0;
  int n_checks = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  link_deser_alias_scratch_regs link_deser_alias_scratch_regs_inst (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .TXN_VALID(TXN_VALID), .TXN_ADDR(TXN_ADDR),
    .FWD_VALID(FWD_VALID), .FWD_ADDR(FWD_ADDR), .FWD_REMAPPED(FWD_REMAPPED),
    .PIXEL_CLK(PIXEL_CLK), .AUDIO_PLL_LOCKED(AUDIO_PLL_LOCKED));
  pixel_clock_source pixel_clock_source_inst (.run(pix_run), .half_ns(pix_half),
    .pix(PIXEL_CLK));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task end_sim;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input [7:0] g, input [7:0] lo, input [7:0] hi);
    n_checks++;
    if (g !== lo && (g < lo || g > hi || ^g === 1'bx)) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  // Answer is due one cycle after the strobe; bound of 4 guards a hang
  task rd(input [7:0] a, input [7:0] lo, input [7:0] hi);
    int i;
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    for (i = 0; i < 4 && REG_RVALID !== 1'b1; i++) begin
      @(posedge CORE_CLK);
      #1;
    end
    if (i == 4) begin
      bad_count++;
      end_sim();
    end else chk(REG_RDATA, lo, hi);
  endtask

  task txn(input [6:0] a, input [6:0] e, input r);
    @(posedge CORE_CLK);
    TXN_ADDR <= a;
    TXN_VALID <= 1'b1;
    @(posedge CORE_CLK);
    TXN_VALID <= 1'b0;
    #1;
    chk({7'h00, FWD_VALID}, 8'h01, 8'h01);
    chk({1'b0, FWD_ADDR}, {1'b0, e}, {1'b0, e});
    chk({7'h00, FWD_REMAPPED}, {7'h00, r}, {7'h00, r});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(8'h15, 8'h00, 8'h00);
    rd(8'h17, 8'h00, 8'h00);
    rd(8'h0D, 8'h00, 8'h00);
    rd(8'h18, 8'h00, 8'h00);
    rd(8'h19, 8'h01, 8'h01);
    rd(8'h1B, 8'h00, 8'h00);
    rd(8'h1C, 8'h00, 8'h00);
  endtask

  task t_regs;
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'hFE, 8'hFE);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'hFE, 8'hFE);
    wr(8'h18, 8'hA5);
    wr(8'h19, 8'h5A);
    rd(8'h18, 8'hA5, 8'hA5);
    rd(8'h19, 8'h5A, 8'h5A);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00, 8'h00);
  endtask

  task t_remap;
    wr(8'h15, 8'h40);
    wr(8'h0D, 8'h90);
    wr(8'h16, 8'h42);
    wr(8'h0E, 8'h22);
    txn(7'h20, 7'h48, 1'b1);
    txn(7'h21, 7'h11, 1'b1);
    txn(7'h7F, 7'h7F, 1'b1);
    txn(7'h33, 7'h33, 1'b0);
  endtask

  // Pixel period 40 ns against a 500 ns window gives 12 or 13 edges
  task t_meter;
    pix_run <= 1'b1;
    wr(8'h1B, 8'h0A);
    repeat (25) @(posedge CORE_CLK);
    rd(8'h1B, 8'h03, 8'h08);
    wr(8'h1B, 8'h0A);
    repeat (70) @(posedge CORE_CLK);
    rd(8'h1B, 8'h0B, 8'h0E);
    pix_half <= 8'h0F;
    wr(8'h1B, 8'hFF);
    repeat (1300) @(posedge CORE_CLK);
    rd(8'h1B, 8'hFF, 8'hFF);
    wr(8'h1B, 8'h00);
    repeat (20) @(posedge CORE_CLK);
    rd(8'h1B, 8'h00, 8'h00);
  endtask

  task t_lock;
    @(posedge CORE_CLK);
    AUDIO_PLL_LOCKED <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    rd(8'h1C, 8'h08, 8'h08);
    @(posedge CORE_CLK);
    AUDIO_PLL_LOCKED <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    rd(8'h1C, 8'h00, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_regs();
    t_remap();
    t_meter();
    t_lock();
    end_sim();
  end
endmodule

// File: bench/link_deser_alias_scratch_sva.sv
/*
  Port checker for the alias, scratch and meter register slice.
  Assumes the one clock domain CORE_CLK and RESET_N active low.
*/
`timescale 1ns/1ps
module link_deser_alias_scratch_sva (
  // Clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // Register side
  input wire [7:0] REG_ADDR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  // Forwarding side
  input wire TXN_VALID,
  input wire [6:0] TXN_ADDR,
  input wire FWD_VALID,
  input wire [6:0] FWD_ADDR,
  input wire FWD_REMAPPED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  rd_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read gave no answer");
  rd_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("answer without read");
  rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
    else $error("read data moved");
  alias_bit0_a: assert property (REG_RD && REG_ADDR[7:2] == 6'h05 &&
    REG_ADDR[1:0] != 2'h0 |=> !REG_RDATA[0]) else $error("alias bit0 set");
  status_bits_a: assert property (REG_RD && REG_ADDR == 8'h1C |=>
    REG_RDATA[7:4] == 4'h0 && REG_RDATA[2:0] == 3'h0) else $error("status bits");
  fwd_answer_a: assert property (TXN_VALID |=> FWD_VALID)
    else $error("no forward");
  fwd_cause_a: assert property (FWD_VALID |-> $past(TXN_VALID))
    else $error("forward without cause");
  fwd_pass_a: assert property (FWD_VALID && !FWD_REMAPPED |->
    FWD_ADDR == $past(TXN_ADDR)) else $error("address changed");
  fwd_hold_a: assert property (!FWD_VALID |-> $stable(FWD_ADDR))
    else $error("forward address moved");
endmodule

bind link_deser_alias_scratch_regs link_deser_alias_scratch_sva link_deser_alias_scratch_sva_inst (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .TXN_VALID(TXN_VALID),
  .TXN_ADDR(TXN_ADDR), .FWD_VALID(FWD_VALID), .FWD_ADDR(FWD_ADDR),
  .FWD_REMAPPED(FWD_REMAPPED));

// File: bench/pixel_clock_source.sv
/*
  Pixel clock source for the meter.
  Assumes the bench sets the half period in ns; low while stopped.
*/
`timescale 1ns/1ps
module pixel_clock_source (
  // Control
  input wire run,
  input wire [7:0] half_ns,
  // Pin
  output logic pix
);
  initial pix = 1'b0;
  always begin
    if (run) begin
      #(half_ns);
      pix = ~pix;
    end else begin
      pix = 1'b0;
      #1;
    end
  end
endmodule

// File: src/link_deser_alias_scratch_defines.vh
/*
  Register offsets, reset values, field positions and timing figures
  for the alias, scratch and pixel-rate register slice.
  Assumes it is included by its bare name from the design files under src/.
*/
`ifndef LINK_DESER_ALIAS_SCRATCH_DEFINES_VH
`define LINK_DESER_ALIAS_SCRATCH_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PHYS_ADDR_5 8'h0D
`define OFS_PHYS_ADDR_6 8'h0E
`define OFS_PHYS_ADDR_7 8'h0F
`define OFS_ALIAS_5 8'h15
`define OFS_ALIAS_6 8'h16
`define OFS_ALIAS_7 8'h17
`define OFS_SCRATCH_0 8'h18
`define OFS_SCRATCH_1 8'h19
`define OFS_RATE_METER 8'h1B
`define OFS_STATUS 8'h1C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ADDR7 7'h00
`define RST_SCRATCH_0 8'h00
`define RST_SCRATCH_1 8'h01
`define RST_BYTE 8'h00

// ----------------------------------------
// Field positions and constants
// ----------------------------------------
`define ADDR_FIELD_HI 7
`define ADDR_FIELD_LO 1
`define STATUS_AUDIO_LOCK_BIT 3
`define METER_SAT 8'hFF
`define METER_ONE 8'h01
`define ALIAS_NONE 7'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_PERIOD_NS 50
`define CORE_PERIOD_NS 10
`define OSC_DIV_CYCLES ((`OSC_PERIOD_NS / `CORE_PERIOD_NS) < 1 ? 1 : \
  (`OSC_PERIOD_NS / `CORE_PERIOD_NS))

`endif

// File: src/link_deser_alias_scratch_regs.v
/*
  Register slice of a video deserializer control bank: remote alias
  entries 5..7 with their physical addresses, two scratch bytes, the
  pixel-rate meter and the general status byte, plus alias remapping of
  transactions headed for the back channel.
  Assumes the serial control bus front end delivers decoded one-cycle
  read and write strobes on CORE_CLK, and that the back channel forwarder
  takes one remapped address per valid pulse.
*/
// What this block does
// - A transaction aimed at a programmed alias is forwarded with the paired physical address.
// - Each alias entry holds a seven-bit address in bits 7:1, bit 0 reserved, RW, reset zero.
// - Each alias entry pairs by index with its own seven-bit physical address register.
// - Two read/write scratch bytes without side effects reset to zero and one.
// - A write to the meter register starts a pixel clock edge count.
// - The count window lasts the written value times the 50 ns oscillator period.
// - A read of the meter register returns the edge count, not the written value.
// - The meter count saturates at all ones and never wraps.
// - Status bit 3 reads one while the audio clock PLL is locked, zero otherwise and at reset.
`timescale 1ns/1ps
`include "link_deser_alias_scratch_defines.vh"

module link_deser_alias_scratch_regs #(
  parameter OSC_DIV = `OSC_DIV_CYCLES,
  parameter NUM_ALIAS = 3
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire RESET_N,
  // Decoded register access
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  // Transactions bound for the back channel
  input wire TXN_VALID,
  input wire [6:0] TXN_ADDR,
  output reg FWD_VALID,
  output reg [6:0] FWD_ADDR,
  output reg FWD_REMAPPED,
  // Pins
  input wire PIXEL_CLK,
  input wire AUDIO_PLL_LOCKED
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // An all-zero alias is treated as unprogrammed so reset state never steals traffic
  function alias_hit;
    input [6:0] alias_addr;
    input [6:0] target;
    begin
      alias_hit = (alias_addr != `ALIAS_NONE) && (alias_addr == target);
    end
  endfunction

  // Reserved bit 0 always reads back as zero
  function [7:0] addr_byte;
    input [6:0] addr7;
    begin
      addr_byte = {addr7, 1'b0};
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Index 0 to 2 stands for entries 5 to 7
  reg [6:0] alias_q [0:NUM_ALIAS-1];
  reg [6:0] phys_q [0:NUM_ALIAS-1];
  reg [7:0] scratch0_q;
  reg [7:0] scratch1_q;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Strobes last one cycle, so each decode fires once per access
  wire wr_alias5;
  wire wr_alias6;
  wire wr_alias7;
  wire wr_phys5;
  wire wr_phys6;
  wire wr_phys7;
  wire wr_scratch0;
  wire wr_scratch1;
  wire wr_meter;

  assign wr_alias5 = REG_WR && (REG_ADDR == `OFS_ALIAS_5);
  assign wr_alias6 = REG_WR && (REG_ADDR == `OFS_ALIAS_6);
  assign wr_alias7 = REG_WR && (REG_ADDR == `OFS_ALIAS_7);
  assign wr_phys5 = REG_WR && (REG_ADDR == `OFS_PHYS_ADDR_5);
  assign wr_phys6 = REG_WR && (REG_ADDR == `OFS_PHYS_ADDR_6);
  assign wr_phys7 = REG_WR && (REG_ADDR == `OFS_PHYS_ADDR_7);
  assign wr_scratch0 = REG_WR && (REG_ADDR == `OFS_SCRATCH_0);
  assign wr_scratch1 = REG_WR && (REG_ADDR == `OFS_SCRATCH_1);
  assign wr_meter = REG_WR && (REG_ADDR == `OFS_RATE_METER);

  // ----------------------------------------
  // Alias entries
  // ----------------------------------------
  // Bit 0 of a written byte is reserved and dropped
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alias_q[0] <= `RST_ADDR7;
      alias_q[1] <= `RST_ADDR7;
      alias_q[2] <= `RST_ADDR7;
    end else begin
      if (wr_alias5) begin
        alias_q[0] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
      if (wr_alias6) begin
        alias_q[1] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
      if (wr_alias7) begin
        alias_q[2] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
    end
  end

  // ----------------------------------------
  // Physical address entries
  // ----------------------------------------
  // Same reserved-bit handling as the alias entries
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phys_q[0] <= `RST_ADDR7;
      phys_q[1] <= `RST_ADDR7;
      phys_q[2] <= `RST_ADDR7;
    end else begin
      if (wr_phys5) begin
        phys_q[0] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
      if (wr_phys6) begin
        phys_q[1] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
      if (wr_phys7) begin
        phys_q[2] <= REG_WDATA[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
      end
    end
  end

  // ----------------------------------------
  // Scratch bytes
  // ----------------------------------------
  // Plain storage: software uses them for arbitration, so no side effects
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scratch0_q <= `RST_SCRATCH_0;
      scratch1_q <= `RST_SCRATCH_1;
    end else begin
      if (wr_scratch0) begin
        scratch0_q <= REG_WDATA;
      end
      if (wr_scratch1) begin
        scratch1_q <= REG_WDATA;
      end
    end
  end

  // ----------------------------------------
  // Pixel-rate meter
  // ----------------------------------------
  // Only the edge count is readable; the busy flag stays internal
  wire [7:0] meter_count;

  pixel_rate_meter_core #(
    .OSC_DIV(OSC_DIV),
    .CNT_W(8)
  ) u_meter (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .start(wr_meter),
    .interval(REG_WDATA),
    .pix_clk_pin(PIXEL_CLK),
    .count_q(meter_count),
    .busy_q()
  );

  // ----------------------------------------
  // Audio lock synchroniser
  // ----------------------------------------
  // Lock flag comes from the audio clock domain
  reg lock_s1_q;
  reg lock_s2_q;

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= AUDIO_PLL_LOCKED;
      lock_s2_q <= lock_s1_q;
    end
  end

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  // Only the lock bit lives in this slice; the others read zero
  reg [7:0] status_byte;

  always @* begin
    status_byte = `RST_BYTE;
    status_byte[`STATUS_AUDIO_LOCK_BIT] = lock_s2_q;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped offsets read zero instead of stale data
  reg [7:0] rd_mux;

  always @* begin
    case (REG_ADDR)
      `OFS_ALIAS_5: begin
        rd_mux = addr_byte(alias_q[0]);
      end
      `OFS_ALIAS_6: begin
        rd_mux = addr_byte(alias_q[1]);
      end
      `OFS_ALIAS_7: begin
        rd_mux = addr_byte(alias_q[2]);
      end
      `OFS_PHYS_ADDR_5: begin
        rd_mux = addr_byte(phys_q[0]);
      end
      `OFS_PHYS_ADDR_6: begin
        rd_mux = addr_byte(phys_q[1]);
      end
      `OFS_PHYS_ADDR_7: begin
        rd_mux = addr_byte(phys_q[2]);
      end
      `OFS_SCRATCH_0: begin
        rd_mux = scratch0_q;
      end
      `OFS_SCRATCH_1: begin
        rd_mux = scratch1_q;
      end
      `OFS_RATE_METER: begin
        rd_mux = meter_count;
      end
      `OFS_STATUS: begin
        rd_mux = status_byte;
      end
      default: begin
        rd_mux = `RST_BYTE;
      end
    endcase
  end

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= `RST_BYTE;
      REG_RVALID <= 1'b0;
    end else begin
      // Data holds between reads so the front end may take it late
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Alias remapping
  // ----------------------------------------
  // Lowest entry wins when software programs the same alias twice
  reg hit_any;
  reg [6:0] remap_addr;
  // Loop index only; no hardware of its own
  integer i;

  always @* begin
    hit_any = 1'b0;
    remap_addr = TXN_ADDR;
    for (i = NUM_ALIAS - 1; i >= 0; i = i - 1) begin
      if (alias_hit(alias_q[i], TXN_ADDR)) begin
        hit_any = 1'b1;
        remap_addr = phys_q[i];
      end
    end
  end

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FWD_VALID <= 1'b0;
      FWD_ADDR <= `RST_ADDR7;
      FWD_REMAPPED <= 1'b0;
    end else begin
      // Address and flag hold; only the valid flag pulses
      FWD_VALID <= TXN_VALID;
      if (TXN_VALID) begin
        FWD_ADDR <= remap_addr;
        FWD_REMAPPED <= hit_any;
      end
    end
  end

endmodule

// File: src/pixel_rate_meter_core.v
/*
  Pixel-rate meter: counts rising pixel clock edges during a window of
  a given number of oscillator periods, saturating at all ones.
  Assumes CORE_CLK clocks everything; the pixel clock is a raw pin.
*/
`timescale 1ns/1ps
`include "link_deser_alias_scratch_defines.vh"

module pixel_rate_meter_core #(
  parameter OSC_DIV = `OSC_DIV_CYCLES,
  parameter CNT_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire start,
  input wire [7:0] interval,
  // Pixel clock pin
  input wire pix_clk_pin,
  // Result
  output reg [7:0] count_q,
  output reg busy_q
);

  // ----------------------------------------
  // Pixel edge synchroniser
  // ----------------------------------------
  // Edges above half the core rate alias; the result is only a rough figure
  reg pix_s1_q;
  reg pix_s2_q;
  reg pix_s3_q;
  wire pix_rise;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_s1_q <= 1'b0;
      pix_s2_q <= 1'b0;
      pix_s3_q <= 1'b0;
    end else begin
      pix_s1_q <= pix_clk_pin;
      pix_s2_q <= pix_s1_q;
      pix_s3_q <= pix_s2_q;
    end
  end

  assign pix_rise = pix_s2_q & ~pix_s3_q;

  // ----------------------------------------
  // Oscillator tick divider
  // ----------------------------------------
  reg [CNT_W-1:0] osc_cnt_q;
  wire osc_tick;

  assign osc_tick = (osc_cnt_q == OSC_DIV[CNT_W-1:0] - 1'b1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= {CNT_W{1'b0}};
    end else if (start || osc_tick) begin
      osc_cnt_q <= {CNT_W{1'b0}};
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Measurement window and counter
  // ----------------------------------------
  reg [7:0] ticks_left_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks_left_q <= `RST_BYTE;
      count_q <= `RST_BYTE;
      busy_q <= 1'b0;
    end else if (start) begin
      ticks_left_q <= interval;
      count_q <= `RST_BYTE;
      busy_q <= (interval != `RST_BYTE);
    end else if (busy_q) begin
      if (pix_rise && count_q != `METER_SAT) begin
        count_q <= count_q + `METER_ONE;
      end
      if (osc_tick) begin
        ticks_left_q <= ticks_left_q - `METER_ONE;
        if (ticks_left_q == `METER_ONE) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

endmodule
